// ---- rtl/serial_ctrl_command_wait_request.sv ----
// Operation
// - Null CRC code does nothing
// - Code 01 and receiver off reset checker
// - Code 10 resets transmit CRC only
// - Code 11 clears underrun latch; append CRC
// - SDLC abort-on-underrun sends abort and flag
// - CRC start sets latch; reset only with transmitter on
// - Transmitter off: latch kept, status interrupt
// - Null command code does nothing
// - Select field plus point high adds eight
// - Status bits latch; reset command rearms
// - Only persisting second change interrupts again
// - Abort command sends ones in SDLC only, flushes, sets latch
// - Code 100 rearms first-character interrupt
// - Code 101 blocks transmit-empty interrupt
// - Code 110 clears errors, releases held character
// - Code 111 resets highest in-service bit
// - Disabled pin sits in inactive state
// - Function bit picks request or wait
// - Direction bit picks buffer; mirror pin
// - Request waits for bus cycle end
// - One-cycle request pulse after CRC
// - Wait on early read or write
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl_defines.svh"

module serial_ctrl_command_wait_request
    import serial_ctrl_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  chan_rst,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  cpu_cycle,
    input  wire logic                  cpu_data_rd,
    input  wire logic                  cpu_data_wr,
    input  wire logic [`EXT_WIDTH-1:0] ext_in,
    input  wire chan_status_type       st,
    output action_type                 act,
    output logic [3:0]                 reg_pointer,
    output logic [7:0]                 transfer_mode,
    output logic                       eom_latch,
    output logic                       underrun_status,
    output logic [`EXT_WIDTH-1:0]      ext_status,
    output logic                       ext_int_pending,
    output logic                       rx_hold,
    output logic                       wreq_out,
    output logic                       wreq_oe_n,
    output logic                       dtr_req_out
);

    cmd_state_type q;
    cmd_state_type s;
    logic          wr_cmd;
    logic [1:0]    crc_f;
    logic [2:0]    code_f;
    logic          rst_ext;
    logic          eom_ev;
    logic [1:0]    rx_mode;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    assign wr_cmd  = reg_wr && (q.pointer == `REG_CHANNEL_COMMAND);
    assign crc_f   = reg_wdata[`CMD_CRC_MSB:`CMD_CRC_LSB];
    assign code_f  = reg_wdata[`CMD_CODE_MSB:`CMD_CODE_LSB];
    assign rst_ext = wr_cmd && (code_f == `CODE_RST_EXT);
    assign rx_mode = q.mode[`MODE_RX_MSB:`MODE_RX_LSB];
    assign eom_ev  = wr_cmd && (crc_f == `CRC_EOM_RESET) && !st.tx_enabled &&
                     (!q.ext_pend || rst_ext);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s = q;
        s.act = '0;
        s.rx_en_d = st.rx_enabled;

        if (reg_wr || reg_rd) begin
            s.pointer = `POINTER_RESET;
        end
        if (wr_cmd) begin
            s.pointer = {code_f == `CODE_POINT_HIGH, reg_wdata[`CMD_SEL_MSB:`CMD_SEL_LSB]};
        end
        if (reg_wr && (q.pointer == `REG_INTERRUPT_TRANSFER_MODE)) begin
            s.mode = reg_wdata;
        end

        s.act.rx_crc_init = (wr_cmd && (crc_f == `CRC_RX_INIT)) ||
                            (q.rx_en_d && !st.rx_enabled) ||
                            (st.sdlc_mode && st.rx_frame_start);
        s.act.tx_crc_init = wr_cmd && (crc_f == `CRC_TX_INIT);

        if (wr_cmd && (crc_f == `CRC_EOM_RESET) && st.tx_enabled) begin
            s.eom_latch = 1'b0;
        end
        if (st.tx_underrun && !q.eom_latch) begin
            if (st.sdlc_mode && st.abort_on_underrun) begin
                s.act.tx_abort_flag = 1'b1;
            end else begin
                s.act.tx_append_crc = 1'b1;
            end
        end

        if (wr_cmd && (code_f == `CODE_SEND_ABORT)) begin
            s.act.send_abort   = st.sdlc_mode;
            s.act.tx_buf_flush = 1'b1;
        end
        if (st.crc_tx_start || (wr_cmd && (code_f == `CODE_SEND_ABORT))) begin
            s.eom_latch = 1'b1;
        end

        if (rst_ext) begin
            s.ext_pend = 1'b0;
        end
        if (!q.ext_pend) begin
            s.underrun_view = q.eom_latch;
        end
        if (!q.mode[`MODE_EXT_IE]) begin
            s.ext_latched = ext_in;
        end else if ((!q.ext_pend || rst_ext) && (ext_in != q.ext_latched)) begin
            s.ext_pend    = 1'b1;
            s.ext_latched = ext_in;
        end
        if (eom_ev && q.mode[`MODE_EXT_IE]) begin
            s.ext_pend      = 1'b1;
            s.underrun_view = 1'b0;
        end

        if (q.first_armed && (rx_mode == `RX_MODE_FIRST) &&
            (st.rx_char_in || st.rx_char_avail)) begin
            s.act.rx_int_req = 1'b1;
            s.first_armed    = 1'b0;
        end
        // First character rearm
        // Rearm wins over a character taken in the same cycle
        if (wr_cmd && (code_f == `CODE_RX_NEXT)) begin
            s.first_armed = 1'b1;
        end
        if ((rx_mode == `RX_MODE_ALL) && st.rx_char_in) begin
            s.act.rx_int_req = 1'b1;
        end
        if ((rx_mode != `RX_MODE_OFF) && st.rx_special) begin
            s.act.rx_int_req = 1'b1;
        end

        if (wr_cmd && (code_f == `CODE_ERR_RESET)) begin
            s.act.error_reset = 1'b1;
            s.act.rx_discard  = q.rx_hold && st.rx_char_unread;
            s.rx_hold         = 1'b0;
        end
        // New special condition beats the clear in the same cycle
        if (st.rx_special && ((rx_mode == `RX_MODE_FIRST) || (rx_mode == `RX_MODE_SPECIAL))) begin
            s.rx_hold = 1'b1;
        end

        if (wr_cmd && (code_f == `CODE_RST_TX_INT)) begin
            s.tx_int_block = 1'b1;
        end else if (st.tx_buf_load || st.crc_tx_done) begin
            s.tx_int_block = 1'b0;
        end
        s.act.tx_int_req = q.mode[`MODE_TX_IE] && st.tx_buf_empty && !s.tx_int_block;

        s.act.ius_reset = wr_cmd && (code_f == `CODE_RST_IUS);

        // Channel reset leaves the transmit CRC generator alone
        if (chan_rst) begin
            s               = '0;
            s.mode          = `MODE_RESET;
            s.eom_latch     = `EOM_RESET;
            s.underrun_view = `EOM_RESET;
            s.ext_latched   = ext_in;
            s.rx_en_d       = st.rx_enabled;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q               <= '0;
            q.mode          <= `MODE_RESET;
            q.eom_latch     <= `EOM_RESET;
            q.underrun_view <= `EOM_RESET;
        end else begin
            q <= s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign act             = q.act;
    assign reg_pointer     = q.pointer;
    assign transfer_mode   = q.mode;
    assign eom_latch       = q.eom_latch;
    assign underrun_status = q.underrun_view;
    assign ext_status      = q.ext_latched;
    assign ext_int_pending = q.ext_pend;
    assign rx_hold         = q.rx_hold;

    wait_request_ctrl u_wreq (
        .clk          (clk),
        .arst_n       (arst_n),
        .chan_rst     (chan_rst),
        .wreq_en      (q.mode[`MODE_WREQ_EN]),
        .wreq_func    (q.mode[`MODE_WREQ_FUNC]),
        .wreq_dir     (q.mode[`MODE_WREQ_DIR]),
        .sync_or_sdlc (st.sync_mode || st.sdlc_mode),
        .crc_tx_done  (st.crc_tx_done),
        .rx_char_avail(st.rx_char_avail),
        .tx_buf_full  (st.tx_buf_full),
        .cpu_cycle    (cpu_cycle),
        .cpu_data_rd  (cpu_data_rd),
        .cpu_data_wr  (cpu_data_wr),
        .wreq_out     (wreq_out),
        .wreq_oe_n    (wreq_oe_n),
        .dtr_req_out  (dtr_req_out)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_cmd(logic [1:0] c);
        wr_cmd && (crc_f == c) && !chan_rst;
    endsequence

    property p_null_crc;
        s_cmd(`CRC_NULL) && !(q.rx_en_d && !st.rx_enabled) && !st.rx_frame_start
            |=> !act.rx_crc_init && !act.tx_crc_init;
    endproperty
    a_null_crc: assert property (p_null_crc) else $error("null code acted");

    property p_rx_init;
        s_cmd(`CRC_RX_INIT) |=> act.rx_crc_init;
    endproperty
    a_rx_init: assert property (p_rx_init) else $error("no rx crc init");

    property p_tx_init_rst;
        chan_rst |=> !act.tx_crc_init;
    endproperty
    a_tx_init_rst: assert property (p_tx_init_rst) else $error("reset hit tx crc");

    property p_eom_clear;
        s_cmd(`CRC_EOM_RESET) && st.tx_enabled && !st.crc_tx_start &&
            (code_f != `CODE_SEND_ABORT) ##1 st.tx_underrun && !st.abort_on_underrun && !chan_rst
            |=> act.tx_append_crc;
    endproperty
    a_eom_clear: assert property (p_eom_clear) else $error("crc not appended");

    property p_abort_flag;
        st.tx_underrun && !q.eom_latch && st.sdlc_mode && st.abort_on_underrun && !chan_rst
            |=> act.tx_abort_flag && !act.tx_append_crc;
    endproperty
    a_abort_flag: assert property (p_abort_flag) else $error("no abort on underrun");

    property p_eom_set;
        st.crc_tx_start |=> eom_latch;
    endproperty
    a_eom_set: assert property (p_eom_set) else $error("latch not set");

    property p_eom_disabled;
        s_cmd(`CRC_EOM_RESET) && !st.tx_enabled && q.eom_latch && !q.ext_pend &&
            q.mode[`MODE_EXT_IE] |=> eom_latch && ext_int_pending && !underrun_status;
    endproperty
    a_eom_disabled: assert property (p_eom_disabled) else $error("disabled latch reset");

    property p_point_high;
        wr_cmd && !chan_rst |=> reg_pointer ==
            {$past(code_f) == `CODE_POINT_HIGH, $past(reg_wdata[`CMD_SEL_MSB:`CMD_SEL_LSB])};
    endproperty
    a_point_high: assert property (p_point_high) else $error("bad pointer");

    property p_ext_rearm;
        rst_ext && q.ext_pend && (ext_in == q.ext_latched) && !eom_ev && !chan_rst
            |=> !ext_int_pending;
    endproperty
    a_ext_rearm: assert property (p_ext_rearm) else $error("status not rearmed");

    property p_ext_requeue;
        rst_ext && q.mode[`MODE_EXT_IE] && (ext_in != q.ext_latched) && !chan_rst
            |=> ext_int_pending && (ext_status == $past(ext_in));
    endproperty
    a_ext_requeue: assert property (p_ext_requeue) else $error("change lost");

    property p_send_abort;
        wr_cmd && (code_f == `CODE_SEND_ABORT) && !chan_rst |=> act.tx_buf_flush && eom_latch;
    endproperty
    a_send_abort: assert property (p_send_abort) else $error("abort incomplete");

    property p_tx_block;
        wr_cmd && (code_f == `CODE_RST_TX_INT) && !chan_rst |=> !act.tx_int_req;
    endproperty
    a_tx_block: assert property (p_tx_block) else $error("tx int not blocked");

endmodule // serial_ctrl_command_wait_request

`default_nettype wire

// ---- rtl/serial_ctrl_defines.svh ----
`ifndef SERIAL_CTRL_DEFINES_SVH
`define SERIAL_CTRL_DEFINES_SVH

// ----------------------------------------------------------------
// Register pointer values
// ----------------------------------------------------------------
`define REG_CHANNEL_COMMAND          4'h0
`define REG_INTERRUPT_TRANSFER_MODE  4'h1
`define POINTER_RESET                4'h0

// ----------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------
`define CMD_CRC_MSB      7
`define CMD_CRC_LSB      6
`define CMD_CODE_MSB     5
`define CMD_CODE_LSB     3
`define CMD_SEL_MSB      2
`define CMD_SEL_LSB      0

`define CRC_NULL         2'h0
`define CRC_RX_INIT      2'h1
`define CRC_TX_INIT      2'h2
`define CRC_EOM_RESET    2'h3

`define CODE_NULL        3'h0
`define CODE_POINT_HIGH  3'h1
`define CODE_RST_EXT     3'h2
`define CODE_SEND_ABORT  3'h3
`define CODE_RX_NEXT     3'h4
`define CODE_RST_TX_INT  3'h5
`define CODE_ERR_RESET   3'h6
`define CODE_RST_IUS     3'h7

// ----------------------------------------------------------------
// Interrupt/transfer mode fields
// ----------------------------------------------------------------
`define MODE_WREQ_EN     7
`define MODE_WREQ_FUNC   6
`define MODE_WREQ_DIR    5
`define MODE_RX_MSB      4
`define MODE_RX_LSB      3
`define MODE_TX_IE       1
`define MODE_EXT_IE      0
`define MODE_RESET       8'h00

`define RX_MODE_OFF      2'h0
`define RX_MODE_FIRST    2'h1
`define RX_MODE_ALL      2'h2
`define RX_MODE_SPECIAL  2'h3

`define EXT_WIDTH        5
`define EOM_RESET        1'b1

`endif

// ---- rtl/serial_ctrl_pkg.sv ----
`include "serial_ctrl_defines.svh"

package serial_ctrl_pkg;

    typedef struct packed {
        logic tx_enabled;
        logic rx_enabled;
        logic sdlc_mode;
        logic sync_mode;
        logic abort_on_underrun;
        logic tx_underrun;
        logic crc_tx_start;
        logic crc_tx_done;
        logic tx_buf_load;
        logic tx_buf_full;
        logic tx_buf_empty;
        logic rx_char_in;
        logic rx_char_avail;
        logic rx_special;
        logic rx_char_unread;
        logic rx_frame_start;
    } chan_status_type;

    typedef struct packed {
        logic rx_crc_init;
        logic tx_crc_init;
        logic tx_append_crc;
        logic tx_abort_flag;
        logic send_abort;
        logic tx_buf_flush;
        logic error_reset;
        logic rx_discard;
        logic ius_reset;
        logic rx_int_req;
        logic tx_int_req;
    } action_type;

    typedef struct packed {
        logic [3:0]              pointer;
        logic [7:0]              mode;
        logic                    eom_latch;
        logic                    underrun_view;
        logic                    ext_pend;
        logic [`EXT_WIDTH-1:0]   ext_latched;
        logic                    first_armed;
        logic                    tx_int_block;
        logic                    rx_hold;
        logic                    rx_en_d;
        action_type              act;
    } cmd_state_type;

    typedef struct packed {
        logic req;
        logic pulse;
    } wreq_state_type;

endpackage

// ---- rtl/wait_request_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl_defines.svh"

module wait_request_ctrl
    import serial_ctrl_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic chan_rst,
    input  wire logic wreq_en,
    input  wire logic wreq_func,
    input  wire logic wreq_dir,
    input  wire logic sync_or_sdlc,
    input  wire logic crc_tx_done,
    input  wire logic rx_char_avail,
    input  wire logic tx_buf_full,
    input  wire logic cpu_cycle,
    input  wire logic cpu_data_rd,
    input  wire logic cpu_data_wr,
    output logic      wreq_out,
    output logic      wreq_oe_n,
    output logic      dtr_req_out
);

    wreq_state_type q;
    wreq_state_type s;
    logic           wait_now;

    always_comb begin
        s = q;
        s.pulse = 1'b0;
        if (!cpu_cycle) begin
            s.req = wreq_dir ? rx_char_avail : !tx_buf_full;
        end
        if (wreq_en && wreq_func && !wreq_dir && sync_or_sdlc && crc_tx_done) begin
            s.pulse = 1'b1;
        end
        if (chan_rst) begin
            s = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= s;
        end
    end

    assign wait_now = wreq_en && !wreq_func && cpu_cycle &&
                      (wreq_dir ? (cpu_data_rd && !rx_char_avail) : (cpu_data_wr && tx_buf_full));
    assign wreq_oe_n = !(wreq_func || wait_now);
    assign wreq_out  = wreq_func ? !(wreq_en && (q.req || q.pulse)) : 1'b0;
    assign dtr_req_out = (wreq_en && wreq_func && !wreq_dir) ? wreq_out : 1'b1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_disabled_idle;
        !wreq_en |-> (wreq_func ? (!wreq_oe_n && wreq_out) : wreq_oe_n);
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("pin not idle");

    property p_req_held;
        cpu_cycle && !chan_rst |=> $stable(q.req);
    endproperty
    a_req_held: assert property (p_req_held) else $error("request moved in cycle");

    property p_crc_pulse;
        wreq_en && wreq_func && !wreq_dir && sync_or_sdlc && crc_tx_done && !chan_rst
            ##1 wreq_en && wreq_func |-> !wreq_out && !wreq_oe_n;
    endproperty
    a_crc_pulse: assert property (p_crc_pulse) else $error("no crc pulse");

    property p_wait_tx;
        wreq_en && !wreq_func && !wreq_dir && cpu_cycle && cpu_data_wr && tx_buf_full
            |-> !wreq_oe_n && !wreq_out;
    endproperty
    a_wait_tx: assert property (p_wait_tx) else $error("wait not driven");

endmodule // wait_request_ctrl

`default_nettype wire

// ---- verif/host_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata,
    output logic            cpu_cycle,
    output logic            cpu_data_rd,
    output logic            cpu_data_wr
);
    initial begin
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        reg_wdata   = 8'h00;
        cpu_cycle   = 1'b0;
        cpu_data_rd = 1'b0;
        cpu_data_wr = 1'b0;
    end

    // Released data bus shows the inverse, so stale data never looks valid
    task automatic put(input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // Pointer select first, then the data write
    task automatic write_reg(input logic [2:0] sel, input logic [7:0] d);
        if (sel != 3'h0) begin
            put({5'h00, sel});
        end
        put(d);
    endtask

    task automatic read_reg();
        @(posedge clk);
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // Level bus cycle; the caller holds it as long as the access stalls
    task automatic data_cycle(input logic rd, input logic wr, input logic on);
        @(posedge clk);
        cpu_cycle   <= on;
        cpu_data_rd <= rd & on;
        cpu_data_wr <= wr & on;
    endtask
endmodule // host_bus_model

`default_nettype wire

// ---- verif/tb_serial_ctrl_command_wait_request.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl_defines.svh"

module tb_serial_ctrl_command_wait_request;
    import serial_ctrl_pkg::*;

    typedef struct packed {
        logic [7:0]  wdata;
        logic [10:0] act;
        logic [3:0]  ptr;
        logic        end_of_message;
    } row_type;

    logic                  clk;
    logic                  arst_n;
    logic                  chan_rst;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [7:0]            reg_wdata;
    logic                  cpu_cycle;
    logic                  cpu_data_rd;
    logic                  cpu_data_wr;
    logic [`EXT_WIDTH-1:0] ext_in;
    chan_status_type       st;
    action_type            act;
    logic [3:0]            reg_pointer;
    logic [7:0]            transfer_mode;
    logic                  eom_latch;
    logic                  underrun_status;
    logic                  rx_hold;
    logic [`EXT_WIDTH-1:0] ext_status;
    logic                  ext_int_pending;
    logic                  wreq_out;
    logic                  wreq_oe_n;
    logic                  dtr_req_out;
    int                    error_cnt;
    int                    num_checks;
    int                    lows;
    row_type               rows [9];

    host_bus_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .cpu_cycle(cpu_cycle), .cpu_data_rd(cpu_data_rd), .cpu_data_wr(cpu_data_wr));

    serial_ctrl_command_wait_request i_dut (.clk(clk), .arst_n(arst_n), .chan_rst(chan_rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .cpu_cycle(cpu_cycle),
        .cpu_data_rd(cpu_data_rd), .cpu_data_wr(cpu_data_wr), .ext_in(ext_in), .st(st),
        .act(act), .reg_pointer(reg_pointer), .transfer_mode(transfer_mode),
        .eom_latch(eom_latch), .underrun_status(underrun_status), .ext_status(ext_status),
        .ext_int_pending(ext_int_pending), .rx_hold(rx_hold), .wreq_out(wreq_out),
        .wreq_oe_n(wreq_oe_n), .dtr_req_out(dtr_req_out));

    always #20 clk = ~clk;

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic check_act(input action_type got, input action_type exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: act got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Command table: all CRC codes, command codes except 2 and 4, transmitter on, SDLC
    // ------------------------------------------------------------
    initial begin
        rows[0] = '{8'h00, 11'h000, 4'h0, 1'b1};
        rows[1] = '{8'h40, 11'h400, 4'h0, 1'b1};
        rows[2] = '{8'h80, 11'h200, 4'h0, 1'b1};
        rows[3] = '{8'hc0, 11'h000, 4'h0, 1'b0};
        rows[4] = '{8'h28, 11'h000, 4'h0, 1'b0};
        rows[5] = '{8'h18, 11'h060, 4'h0, 1'b1};
        rows[6] = '{8'h30, 11'h010, 4'h0, 1'b1};
        rows[7] = '{8'h38, 11'h004, 4'h0, 1'b1};
        rows[8] = '{8'h0b, 11'h000, 4'hb, 1'b1};
    end

    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        results();
    end

    initial begin
        clk = 1'b0; arst_n = 1'b0; chan_rst = 1'b0; ext_in = '0; st = '0;
        error_cnt = 0; num_checks = 0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        check_val({4'h0, reg_pointer}, 8'h00);
        check_val(transfer_mode, 8'h00);
        check_val({6'h00, eom_latch, wreq_oe_n}, 8'h03);
        check_val({7'h00, dtr_req_out}, 8'h01); // idle
        $display("test reset done");
        st.tx_enabled <= 1'b1;
        st.sdlc_mode  <= 1'b1;
        st.tx_buf_full <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            i_host.put(rows[i].wdata);
            #1;
            check_act(act, rows[i].act);
            check_val({4'h0, reg_pointer}, {4'h0, rows[i].ptr});
            check_val({7'h00, eom_latch}, {7'h00, rows[i].end_of_message});
        end
        i_host.read_reg();
        #1;
        check_val({4'h0, reg_pointer}, 8'h00);
        $display("test command table done");
        // Underrun with the latch clear: append, then abort; CRC start sets it
        i_host.put(8'hc0);
        st.tx_underrun <= 1'b1;
        @(posedge clk);
        st.abort_on_underrun <= 1'b1;
        #1;
        check_act(act, 11'h100);
        @(posedge clk);
        st.tx_underrun  <= 1'b0;
        st.crc_tx_start <= 1'b1;
        #1;
        check_act(act, 11'h080);
        @(posedge clk);
        st.crc_tx_start <= 1'b0;
        #1;
        check_val({7'h00, eom_latch}, 8'h01);
        $display("test underrun done");
        // Request on transmit; blocked request held through a bus cycle
        i_host.write_reg(3'h1, 8'hc0);
        #1;
        check_val({5'h00, wreq_oe_n, wreq_out, dtr_req_out}, 8'h03);
        i_host.data_cycle(1'b0, 1'b1, 1'b1);
        st.tx_buf_full <= 1'b0;
        tick(3);
        check_val({7'h00, wreq_out}, 8'h01);
        i_host.data_cycle(1'b0, 1'b0, 1'b0);
        tick(2);
        check_val({6'h00, wreq_out, dtr_req_out}, 8'h00);
        st.tx_buf_full <= 1'b1;
        tick(3);
        st.crc_tx_done <= 1'b1;
        @(posedge clk);
        st.crc_tx_done <= 1'b0;
        lows = 0;
        repeat (4) begin
            #1;
            lows += (wreq_out === 1'b0) ? 1 : 0;
            @(posedge clk);
        end
        check_val(8'(lows), 8'h01);
        $display("test request done");
        // Wait on transmit, then wait on receive
        i_host.write_reg(3'h1, 8'h80);
        i_host.data_cycle(1'b0, 1'b1, 1'b1);
        #1;
        check_val({6'h00, wreq_oe_n, wreq_out}, 8'h00);
        @(posedge clk);
        st.tx_buf_full <= 1'b0;
        #1;
        check_val({7'h00, wreq_oe_n}, 8'h01);
        i_host.data_cycle(1'b0, 1'b0, 1'b0);
        i_host.write_reg(3'h1, 8'ha0);
        i_host.data_cycle(1'b1, 1'b0, 1'b1);
        #1;
        check_val({6'h00, wreq_oe_n, wreq_out}, 8'h00);
        i_host.data_cycle(1'b0, 1'b0, 1'b0);
        i_host.write_reg(3'h1, 8'h40);
        #1;
        check_val({6'h00, wreq_oe_n, wreq_out}, 8'h01);
        i_host.write_reg(3'h1, 8'he0);
        st.rx_char_avail <= 1'b1;
        tick(2);
        check_val({6'h00, wreq_out, dtr_req_out}, 8'h01);
        $display("test wait done");
        // First-character rearm, then a held special character is discarded
        i_host.write_reg(3'h1, 8'h08);
        i_host.put(8'h20);
        tick(1);
        check_act(act, 11'h002);
        tick(1);
        check_act(act, 11'h000);
        st.rx_special     <= 1'b1;
        st.rx_char_unread <= 1'b1;
        @(posedge clk);
        st.rx_special <= 1'b0;
        #1;
        check_val({7'h00, rx_hold}, 8'h01);
        i_host.put(8'h30);
        #1;
        check_val({7'h00, rx_hold}, 8'h00);
        check_act(act, 11'h018);
        $display("test receive commands done");
        // Latch kept when transmitter is off; status interrupt shows it clear
        st.tx_enabled <= 1'b0;
        i_host.write_reg(3'h1, 8'h01);
        i_host.put(8'hc0);
        #1;
        check_val({5'h00, eom_latch, ext_int_pending, underrun_status}, 8'h06);
        i_host.put(8'h10);
        st.tx_enabled <= 1'b1;
        // Status latching; a persisting change requeues, a reverted one does not
        ext_in <= 5'h05;
        tick(2);
        check_val({2'h0, ext_int_pending, ext_status}, 8'h25);
        ext_in <= 5'h07;
        i_host.put(8'h10);
        #1;
        check_val({2'h0, ext_int_pending, ext_status}, 8'h27);
        ext_in <= 5'h0f;
        tick(1);
        ext_in <= 5'h07;
        i_host.put(8'h10);
        tick(1);
        check_val({7'h00, ext_int_pending}, 8'h00);
        // Channel reset leaves the transmit CRC generator alone
        chan_rst <= 1'b1;
        @(posedge clk);
        chan_rst <= 1'b0;
        #1;
        check_act(act, 11'h000);
        check_val(transfer_mode, 8'h00);
        $display("test status and channel reset done");
        results();
    end
endmodule // tb_serial_ctrl_command_wait_request

`default_nettype wire
